// ### core/dnup_port.sv
// Purpose: native user request port with refresh, zq and reinit control
// Assumes: user logic on the same clock, avalon-mm register slave
// Notes: one word per clock on both data paths
//
// The Avalon-MM register port and the register offsets were chosen for this implementation.
module dnup_port (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clk_en,
   input dnup_pkg::dnup_req_s user_req,
   input dnup_pkg::dnup_wdat_s wr_in,
   input wire logic user_refresh_request,
   input wire logic [dnup_pkg::RANKS-1:0] zq_calib_request,
   input wire logic reinit_trigger,
   output logic busy,
   output logic init_done,
   output logic wdata_pull,
   output logic wdata_pull_final,
   output logic rdata_strobe,
   output logic rdata_strobe_final,
   output logic [dnup_pkg::DATA_W-1:0] rdata_bus,
   output logic refresh_ack,
   output logic zq_calib_issued_pulse,
   output logic col_cmd_autopre,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   typedef struct packed {
      dnup_pkg::dnup_state_e state;
      logic [dnup_pkg::CNT_W-1:0] cnt;
      logic [dnup_pkg::BEAT_W-1:0] beats;
      logic [dnup_pkg::IDX_W-1:0] idx;
      logic [dnup_pkg::IDX_W-1:0] widx;
      logic [dnup_pkg::CNT_W-1:0] ap_cnt;
      logic [dnup_pkg::CNT_W-1:0] ref_cnt;
      logic [dnup_pkg::CNT_W-1:0] zq_cnt;
      logic ref_pend;
      logic [dnup_pkg::RANKS-1:0] zq_pend;
      logic [dnup_pkg::RANKS-1:0] zq_user;
      logic reinit_prev;
      logic reinit_pend;
      logic pull_d;
      logic rd_v;
      logic rd_l;
      logic uref;
      logic azq;
      logic [dnup_pkg::CNT_W-1:0] refi;
      logic [dnup_pkg::CNT_W-1:0] zqper;
      logic busy;
      logic ready;
      logic pull;
      logic pull_last;
      logic rstb;
      logic rlast;
      logic [dnup_pkg::DATA_W-1:0] rdata;
      logic ref_ack;
      logic zq_ack;
      logic ap_cmd;
      logic waitreq;
      logic [31:0] rdat;
   } dnup_core_s;

   dnup_core_s st_r;
   dnup_core_s st_nxt;
   dnup_pkg::dnup_mwr_s mw;
   dnup_pkg::dnup_mrd_s mr;
   logic [dnup_pkg::DATA_W-1:0] mem_q;
   logic accept;
   logic reinit_edge;

   function automatic logic [dnup_pkg::BEAT_W-1:0] dnup_beats(
      input logic [dnup_pkg::BSIZE_W-1:0] bytes);
      logic [dnup_pkg::BEAT_W-1:0] n;
      n = bytes[dnup_pkg::BSIZE_W-1:dnup_pkg::WORD_SH]; // RL2
      if (n == '0)
         n = 7'h01;
      return n;
   endfunction : dnup_beats

   function automatic dnup_pkg::dnup_sel_e dnup_sel(
      input logic [3:0] a);
      if (a == dnup_pkg::REG_CTRL)
         return dnup_pkg::SEL_CTRL;
      else if (a == dnup_pkg::REG_REFI)
         return dnup_pkg::SEL_REFI;
      else if (a == dnup_pkg::REG_ZQPER)
         return dnup_pkg::SEL_ZQPER;
      else if (a == dnup_pkg::REG_STAT)
         return dnup_pkg::SEL_STAT;
      else
         return dnup_pkg::SEL_NONE;
   endfunction : dnup_sel

   function automatic logic [31:0] dnup_merge(
      input logic [31:0] old,
      input logic [31:0] wd,
      input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (be[i])
            r[i*8 +: 8] = wd[i*8 +: 8];
      return r;
   endfunction : dnup_merge

   dnup_mem u_mem (
      .clock(clock),
      .clk_en(clk_en),
      .wr(mw),
      .rd(mr),
      .rdata(mem_q)
   );

   assign accept = (user_req.rd_req || user_req.wr_req)
      && !st_r.busy && st_r.state == dnup_pkg::S_IDLE; // RL3
   assign reinit_edge = reinit_trigger && !st_r.reinit_prev; // RL19

   always_comb
   begin
      dnup_pkg::dnup_sel_e sel;
      logic [31:0] stat;
      sel = dnup_sel(avs_address);
      stat = '0;
      st_nxt = st_r;
      mw = '0;
      mr = '0;
      st_nxt.reinit_prev = reinit_trigger;
      st_nxt.pull = 1'b0;
      st_nxt.pull_last = 1'b0;
      st_nxt.ref_ack = 1'b0;
      st_nxt.zq_ack = 1'b0;
      st_nxt.ap_cmd = 1'b0;
      // read pipe: mem output registered onto the bus
      st_nxt.rstb = st_r.rd_v; // RL9
      st_nxt.rlast = st_r.rd_l; // RL10
      if (st_r.rd_v)
         st_nxt.rdata = mem_q;
      st_nxt.rd_v = 1'b0;
      st_nxt.rd_l = 1'b0;
      // write data arrives the cycle after its pull
      st_nxt.pull_d = st_r.pull;
      if (st_r.pull_d)
      begin
         mw.en = 1'b1;
         mw.be = ~wr_in.wbyte_mask; // RL12
         mw.idx = st_r.widx;
         mw.data = wr_in.wdata_bus; // RL7 RL11
         st_nxt.widx = st_r.widx + 4'h1;
      end
      case (st_r.state)
         dnup_pkg::S_INIT:
         begin
            if (st_r.cnt == '0)
            begin
               st_nxt.state = dnup_pkg::S_IDLE;
               st_nxt.ready = 1'b1; // RL22
            end
            else
               st_nxt.cnt = st_r.cnt - 16'h0001; // RL20
         end
         dnup_pkg::S_IDLE:
         begin
            if (accept)
            begin
               st_nxt.idx = user_req.addr[dnup_pkg::WORD_SH +:
                  dnup_pkg::IDX_W]; // RL1
               st_nxt.widx = st_nxt.idx;
               st_nxt.beats = dnup_beats(user_req.burst_bytes);
               st_nxt.state = user_req.wr_req ? dnup_pkg::S_WRITE
                  : dnup_pkg::S_READ;
               st_nxt.ap_cmd = user_req.auto_precharge_flag; // RL6
               if (user_req.auto_precharge_flag)
                  st_nxt.ap_cnt = st_r.ap_cnt + 16'h0001;
            end
            else if (st_r.reinit_pend)
            begin
               st_nxt.state = dnup_pkg::S_INIT;
               st_nxt.cnt = dnup_pkg::INIT_CYC; // RL19
               st_nxt.reinit_pend = 1'b0;
            end
            else if (st_r.ref_pend)
               st_nxt.state = dnup_pkg::S_REF; // RL13
            else if (st_r.zq_pend != '0)
               st_nxt.state = dnup_pkg::S_ZQ;
         end
         dnup_pkg::S_WRITE:
         begin
            if (st_r.beats != '0)
            begin
               st_nxt.pull = 1'b1; // RL7
               st_nxt.pull_last = st_r.beats == 7'h01; // RL8
               st_nxt.beats = st_r.beats - 7'h01;
            end
            else if (!st_r.pull && !st_r.pull_d)
               st_nxt.state = dnup_pkg::S_IDLE;
         end
         dnup_pkg::S_READ:
         begin
            if (st_r.beats != '0)
            begin
               mr.en = 1'b1;
               mr.idx = st_r.idx;
               st_nxt.idx = st_r.idx + 4'h1;
               st_nxt.rd_v = 1'b1;
               st_nxt.rd_l = st_r.beats == 7'h01;
               st_nxt.beats = st_r.beats - 7'h01;
            end
            else
               st_nxt.state = dnup_pkg::S_IDLE;
         end
         dnup_pkg::S_REF:
         begin
            st_nxt.ref_ack = 1'b1; // RL14
            st_nxt.ref_pend = 1'b0;
            st_nxt.state = dnup_pkg::S_IDLE;
         end
         dnup_pkg::S_ZQ:
         begin
            st_nxt.zq_ack = st_r.zq_user != '0; // RL18
            st_nxt.zq_pend = '0;
            st_nxt.zq_user = '0;
            st_nxt.state = dnup_pkg::S_IDLE;
         end
         default:
            st_nxt.state = dnup_pkg::S_INIT;
      endcase
      // timers and request flags, set wins over clear
      if (!st_r.uref)
      begin
         if (st_r.ref_cnt == '0)
         begin
            st_nxt.ref_pend = 1'b1; // RL15
            st_nxt.ref_cnt = st_r.refi;
         end
         else
            st_nxt.ref_cnt = st_r.ref_cnt - 16'h0001;
      end
      else if (user_refresh_request)
         st_nxt.ref_pend = 1'b1; // RL13
      if (st_r.uref)
         st_nxt.ref_cnt = st_r.refi;
      if (st_r.azq)
      begin
         if (st_r.zq_cnt == '0)
         begin
            st_nxt.zq_pend = '1; // RL17
            st_nxt.zq_cnt = st_r.zqper;
         end
         else
            st_nxt.zq_cnt = st_r.zq_cnt - 16'h0001;
      end
      else
         st_nxt.zq_cnt = st_r.zqper;
      st_nxt.zq_pend = st_nxt.zq_pend | zq_calib_request; // RL16
      st_nxt.zq_user = st_nxt.zq_user | zq_calib_request;
      if (reinit_edge)
      begin
         st_nxt.ready = 1'b0; // RL22
         if (st_r.state == dnup_pkg::S_INIT)
         begin
            st_nxt.state = dnup_pkg::S_INIT;
            st_nxt.cnt = dnup_pkg::INIT_CYC;
         end
         else
            st_nxt.reinit_pend = 1'b1;
      end
      st_nxt.busy = st_nxt.state != dnup_pkg::S_IDLE
         || st_nxt.reinit_pend; // RL4 RL24
      // register slave, one wait cycle then the answer
      stat[dnup_pkg::STAT_READY] = st_r.ready;
      stat[dnup_pkg::STAT_BUSY] = st_r.busy;
      stat[dnup_pkg::STAT_REFP] = st_r.ref_pend;
      stat[dnup_pkg::STAT_ZQ_LSB +: dnup_pkg::RANKS] = st_r.zq_pend;
      stat[dnup_pkg::STAT_AP_LSB +: dnup_pkg::CNT_W] = st_r.ap_cnt;
      st_nxt.waitreq = 1'b1;
      if ((avs_read || avs_write) && st_r.waitreq)
      begin
         st_nxt.waitreq = 1'b0;
         st_nxt.rdat = '0;
         if (avs_read)
         begin
            if (sel == dnup_pkg::SEL_CTRL)
               st_nxt.rdat = {30'h0000_0000, st_r.azq, st_r.uref};
            else if (sel == dnup_pkg::SEL_REFI)
               st_nxt.rdat = {16'h0000, st_r.refi};
            else if (sel == dnup_pkg::SEL_ZQPER)
               st_nxt.rdat = {16'h0000, st_r.zqper};
            else if (sel == dnup_pkg::SEL_STAT)
               st_nxt.rdat = stat;
         end
      end
      // a write lands at the edge that ends its answer cycle
      if (avs_write && !st_r.waitreq)
      begin
         if (sel == dnup_pkg::SEL_CTRL && avs_byteenable[0])
         begin
            st_nxt.uref = avs_writedata[dnup_pkg::CTRL_UREF];
            st_nxt.azq = avs_writedata[dnup_pkg::CTRL_AZQ];
         end
         else if (sel == dnup_pkg::SEL_REFI)
            st_nxt.refi = 16'(dnup_merge({16'h0000, st_r.refi},
               avs_writedata, avs_byteenable));
         else if (sel == dnup_pkg::SEL_ZQPER)
            st_nxt.zqper = 16'(dnup_merge({16'h0000, st_r.zqper},
               avs_writedata, avs_byteenable));
      end
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         st_r <= '0; // RL20 RL23
         st_r.state <= dnup_pkg::S_INIT;
         st_r.cnt <= dnup_pkg::INIT_CYC;
         st_r.busy <= 1'b1;
         st_r.reinit_prev <= 1'b1;
         st_r.waitreq <= 1'b1;
         st_r.uref <= dnup_pkg::CTRL_RST[dnup_pkg::CTRL_UREF];
         st_r.azq <= dnup_pkg::CTRL_RST[dnup_pkg::CTRL_AZQ];
         st_r.refi <= dnup_pkg::TREFI_CYC;
         st_r.ref_cnt <= dnup_pkg::TREFI_CYC;
         st_r.zqper <= dnup_pkg::ZQ_PER_CYC;
         st_r.zq_cnt <= dnup_pkg::ZQ_PER_CYC;
      end
      else if (clk_en)
         st_r <= st_nxt;
   end

   assign busy = st_r.busy;
   assign init_done = st_r.ready;
   assign wdata_pull = st_r.pull;
   assign wdata_pull_final = st_r.pull_last;
   assign rdata_strobe = st_r.rstb;
   assign rdata_strobe_final = st_r.rlast;
   assign rdata_bus = st_r.rdata;
   assign refresh_ack = st_r.ref_ack;
   assign zq_calib_issued_pulse = st_r.zq_ack;
   assign col_cmd_autopre = st_r.ap_cmd;
   assign avs_readdata = st_r.rdat;
   assign avs_waitrequest = st_r.waitreq;

   a_accept_req: assert property ( // RL3
      @(posedge clock) disable iff (sys_rst)
      clk_en && accept |=> st_r.state inside
         {dnup_pkg::S_WRITE, dnup_pkg::S_READ})
      else $error("request with busy low not taken");
   a_busy_init: assert property ( // RL24
      @(posedge clock) disable iff (sys_rst)
      !st_r.ready || st_r.state == dnup_pkg::S_INIT |-> st_r.busy)
      else $error("busy low while init in progress");
   a_autopre_cmd: assert property ( // RL6
      @(posedge clock) disable iff (sys_rst)
      clk_en && accept && user_req.auto_precharge_flag
      |=> st_r.ap_cmd)
      else $error("auto-precharge not issued");
   a_pull_write: assert property ( // RL7
      @(posedge clock) disable iff (sys_rst)
      clk_en && st_r.pull |=> st_r.pull_d
         && st_r.state == dnup_pkg::S_WRITE)
      else $error("pulled word not captured in write");
   a_pull_final: assert property ( // RL8
      @(posedge clock) disable iff (sys_rst)
      st_r.pull_last |-> st_r.pull && st_r.beats == '0)
      else $error("final pull not on last word");
   a_read_strobe: assert property ( // RL9
      @(posedge clock) disable iff (sys_rst)
      clk_en && mr.en |=> st_r.rd_v ##0 clk_en [*1] ##1 st_r.rstb)
      else $error("read word not strobed");
   a_read_final: assert property ( // RL10
      @(posedge clock) disable iff (sys_rst)
      st_r.rlast |-> st_r.rstb)
      else $error("final read without strobe");
   a_ref_pulse: assert property ( // RL14
      @(posedge clock) disable iff (sys_rst)
      clk_en && st_r.state == dnup_pkg::S_REF
      |=> st_r.ref_ack ##0 clk_en [*1] ##1 !st_r.ref_ack)
      else $error("refresh ack not one clock");
   a_zq_pulse: assert property ( // RL18
      @(posedge clock) disable iff (sys_rst)
      clk_en && st_r.zq_ack |=> !st_r.zq_ack)
      else $error("zq ack longer than one clock");
   a_reinit_drop: assert property ( // RL19
      @(posedge clock) disable iff (sys_rst)
      clk_en && reinit_edge |=> !st_r.ready)
      else $error("reinit edge did not drop init done");
endmodule : dnup_port

// ### core/dnup_pkg.sv
// Purpose: constants and types for the native user request port
// Assumes: ddr4 target, x16 memory, one 40 MHz clock
// Notes: registers sit behind an avalon-mm slave
// Notes on behaviour
// (RL1) request address is 39 bits for ddr4, 36 bits for ddr3 or lpddr3
// (RL2) requester gives burst size in bytes, a multiple of the bus width
// (RL3) a request is taken when read or write is high and busy low
// (RL4) busy is high whenever new requests cannot be taken
// (RL5) requester may hold a refused request unchanged until busy falls
// (RL6) auto-precharge flag with a request issues the auto-precharge form
// (RL7) write data pulled one clock before use, supplied the next cycle
// (RL8) final-word flag rides with the pull of the last write word
// (RL9) read strobe high in every cycle carrying a valid read word
// (RL10) final-read flag rides with the strobe of the last read word
// (RL11) data buses are 128, 256 or 512 bits for x16, x32, x64 memory
// (RL12) one write mask bit per byte, a set bit masks that byte
// (RL13) in user refresh mode a refresh request issues refresh next chance
// (RL14) refresh acknowledge pulses one clock per refresh issued
// (RL15) automatic refresh spacing follows the refresh interval setting
// (RL16) zq request is per rank; each asserted rank gets calibration
// (RL17) optional automatic zq calibration at a configurable period
// (RL18) zq acknowledge pulses one clock for a user-requested calibration
// (RL19) rising edge of reinit trigger restarts init; level alone does not
// (RL20) init with startup delay always runs after reset
// (RL21) reinit trigger is best tied low when not needed
// (RL22) init done low in reset and after reinit, high once init ends
// (RL23) all control signals active high, synchronous to the clock
// (RL24) busy stays high and no request is taken during init
package dnup_pkg;
   localparam int ADDR_W = 39;
   localparam int BSIZE_W = 11;
   localparam int DATA_W = 128;
   localparam int MASK_W = DATA_W / 8;
   localparam int WORD_SH = 4;
   localparam int BEAT_W = BSIZE_W - WORD_SH;
   localparam int DEPTH = 16;
   localparam int IDX_W = 4;
   localparam int RANKS = 2;
   localparam int CNT_W = 16;
   localparam int CLK_MHZ = 40;
   localparam int INIT_DELAY_NS = 10_000;
   localparam int TREFI_NS = 7_800;
   localparam logic [CNT_W-1:0] INIT_CYC =
      CNT_W'((INIT_DELAY_NS * CLK_MHZ + 999) / 1000);
   localparam logic [CNT_W-1:0] TREFI_CYC =
      CNT_W'(TREFI_NS * CLK_MHZ / 1000);
   localparam logic [CNT_W-1:0] ZQ_PER_CYC = 16'h2000;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_REFI = 4'h4;
   localparam logic [3:0] REG_ZQPER = 4'h8;
   localparam logic [3:0] REG_STAT = 4'hC;
   localparam int CTRL_UREF = 0;
   localparam int CTRL_AZQ = 1;
   localparam int STAT_READY = 0;
   localparam int STAT_BUSY = 1;
   localparam int STAT_REFP = 2;
   localparam int STAT_ZQ_LSB = 4;
   localparam int STAT_AP_LSB = 16;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;

   typedef enum logic [2:0] {
      S_INIT, S_IDLE, S_WRITE, S_READ, S_REF, S_ZQ
   } dnup_state_e;

   typedef enum logic [2:0] {
      SEL_NONE, SEL_CTRL, SEL_REFI, SEL_ZQPER, SEL_STAT
   } dnup_sel_e;

   typedef struct packed {
      logic rd_req;
      logic wr_req;
      logic [ADDR_W-1:0] addr;
      logic [BSIZE_W-1:0] burst_bytes;
      logic auto_precharge_flag;
   } dnup_req_s;

   typedef struct packed {
      logic [DATA_W-1:0] wdata_bus;
      logic [MASK_W-1:0] wbyte_mask;
   } dnup_wdat_s;

   typedef struct packed {
      logic en;
      logic [MASK_W-1:0] be;
      logic [IDX_W-1:0] idx;
      logic [DATA_W-1:0] data;
   } dnup_mwr_s;

   typedef struct packed {
      logic en;
      logic [IDX_W-1:0] idx;
   } dnup_mrd_s;
endpackage : dnup_pkg

// ### core/dnup_mem.sv
// Purpose: small word store behind the native port
// Assumes: byte enables active high, one word per access
// Notes: read data come out of a register one clock after the read
module dnup_mem (
   input wire logic clock,
   input wire logic clk_en,
   input dnup_pkg::dnup_mwr_s wr,
   input dnup_pkg::dnup_mrd_s rd,
   output logic [dnup_pkg::DATA_W-1:0] rdata
);
   typedef struct packed {
      logic [dnup_pkg::DEPTH-1:0][dnup_pkg::DATA_W-1:0] w;
      logic [dnup_pkg::DATA_W-1:0] q;
   } dnup_mem_s;

   dnup_mem_s st_r;
   dnup_mem_s st_nxt;
   logic [dnup_pkg::DATA_W-1:0] merged;

   // per byte merge, masked bytes keep old contents
   for (genvar b = 0; b < dnup_pkg::MASK_W; b++)
   begin : g_byte
      assign merged[b*8 +: 8] = wr.be[b] ? wr.data[b*8 +: 8]
         : st_r.w[wr.idx][b*8 +: 8]; // RL12
   end

   always_comb
   begin
      st_nxt = st_r;
      if (wr.en)
         st_nxt.w[wr.idx] = merged;
      if (rd.en)
         st_nxt.q = st_r.w[rd.idx];
   end

   always_ff @(posedge clock)
   begin
      if (clk_en)
         st_r <= st_nxt;
   end

   assign rdata = st_r.q;
endmodule : dnup_mem

// ### test/dnup_user_model.sv
// Purpose: user fabric side that feeds write words when pulled
// Assumes: a pull seen at an edge means a word is due next cycle
// Notes: between words the bus flips every cycle, starting with the inverse of the last word
module dnup_user_model (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic mask_on,
   input wire logic wdata_pull,
   output dnup_pkg::dnup_wdat_s wr_in
);
   timeunit 1ns;
   timeprecision 1ps;

   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         wr_in <= '0;
      end
      else if (wdata_pull === 1'h1)
      begin
         wr_in.wdata_bus <= {$urandom, $urandom, $urandom, $urandom};
         wr_in.wbyte_mask <= mask_on ? 16'($urandom) : '0;
      end
      else
      begin
         wr_in <= ~wr_in;
      end
   end
endmodule : dnup_user_model

// ### test/tb.sv
// Purpose: self-checking bench of the native user request port
// Assumes: user model feeds write words, one clock domain
// Notes: expected words kept in a shadow store from the fed data
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'h0;
   logic sys_rst = 1'h1;
   dnup_pkg::dnup_req_s user_req = '0;
   dnup_pkg::dnup_wdat_s wr_in;
   logic user_refresh_request = 1'h0;
   logic [dnup_pkg::RANKS-1:0] zq_calib_request = '0;
   logic reinit_trigger = 1'h1;
   logic mask_on = 1'h0;
   logic busy, init_done, wdata_pull, wdata_pull_final, col_cmd_autopre;
   logic rdata_strobe, rdata_strobe_final, refresh_ack, zq_ack;
   logic [dnup_pkg::DATA_W-1:0] rdata_bus;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'h0;
   logic avs_write = 1'h0;
   logic [31:0] avs_writedata = '0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [dnup_pkg::DATA_W-1:0] exp_mem [16];
   logic pull_q = 1'h0;
   int n_fail = 0;
   int checks_done = 0;
   int ap_cnt = 0;
   int widx = 0;
   int cyc = 0;
   int n_ref = 0;
   int n_zq = 0;
   int n_busy = 0;
   int ref_last = 0;
   int ref_gap = 0;

   dnup_port dut (
      .clock(clock), .sys_rst(sys_rst), .clk_en(1'h1),
      .user_req(user_req), .wr_in(wr_in),
      .user_refresh_request(user_refresh_request),
      .zq_calib_request(zq_calib_request), .reinit_trigger(reinit_trigger),
      .busy(busy), .init_done(init_done), .wdata_pull(wdata_pull),
      .wdata_pull_final(wdata_pull_final), .rdata_strobe(rdata_strobe),
      .rdata_strobe_final(rdata_strobe_final), .rdata_bus(rdata_bus),
      .refresh_ack(refresh_ack), .zq_calib_issued_pulse(zq_ack),
      .col_cmd_autopre(col_cmd_autopre), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
   );

   dnup_user_model user (
      .clock(clock), .sys_rst(sys_rst), .mask_on(mask_on),
      .wdata_pull(wdata_pull), .wr_in(wr_in)
   );

   initial
   begin
      forever #12.5 clock = ~clock;
   end

   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      pull_q <= wdata_pull;
      n_busy <= n_busy + int'(busy === 1'h1);
      n_zq <= n_zq + int'(zq_ack === 1'h1);
      if (refresh_ack === 1'h1)
      begin
         n_ref <= n_ref + 1;
         ref_gap <= cyc - ref_last;
         ref_last <= cyc;
      end
      if (pull_q === 1'h1)
      begin
         for (int b = 0; b < dnup_pkg::MASK_W; b++)
            if (wr_in.wbyte_mask[b] === 1'h0)
               exp_mem[widx][8*b +: 8] <= wr_in.wdata_bus[8*b +: 8];
         widx <= (widx + 1) % 16;
      end
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done

   task automatic chk(input logic ok, input string msg);
      checks_done++;
      if (ok !== 1'h1)
      begin
         n_fail++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask : chk

   task automatic give_up(input int t, input int lim);
      if (t >= lim)
      begin
         chk(1'h0, "wait ran out");
         test_done();
      end
   endtask : give_up

   task automatic avs(input logic wr, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] q);
      int t;
      avs_address <= a;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= d;
      t = 0;
      do
      begin
         @(posedge clock);
         t++;
      end
      while (avs_waitrequest !== 1'h0 && t < 50);
      q = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
      give_up(t, 50);
      @(posedge clock);
   endtask : avs

   task automatic wait_init(output int t);
      t = 0;
      do
      begin
         @(posedge clock);
         t++;
      end
      while (init_done !== 1'h1 && t < 1000);
      give_up(t, 1000);
   endtask : wait_init

   task automatic req(input logic wr, input logic [3:0] w, input int beats,
      input logic ap);
      int n;
      int t;
      user_req.rd_req <= !wr;
      user_req.wr_req <= wr;
      user_req.addr <= {31'($urandom), w, 4'h0};
      user_req.burst_bytes <= 11'(beats * 16);
      user_req.auto_precharge_flag <= ap;
      t = 0;
      do
      begin
         @(posedge clock);
         t++;
      end
      while (busy !== 1'h0 && t < 2000);
      give_up(t, 2000);
      if (wr)
         widx = w;
      user_req <= '0;
      ap_cnt += int'(ap);
      @(posedge clock);
      chk(busy === 1'h1, "busy after take");
      chk(col_cmd_autopre === ap, "autopre");
      n = 0;
      t = 0;
      while (n < beats && t < 100)
      begin
         @(posedge clock);
         t++;
         if (wr && wdata_pull === 1'h1)
         begin
            n++;
            chk(wdata_pull_final === (n == beats), "pull final");
         end
         if (!wr && rdata_strobe === 1'h1)
         begin
            chk(rdata_bus === exp_mem[(w + n) % 16], "rdata");
            n++;
            chk(rdata_strobe_final === (n == beats), "rd final");
         end
      end
      give_up(t, 100);
   endtask : req

   initial
   begin
      logic [31:0] q;
      int t;
      int z0;
      void'($urandom(32'h0000_8756));
      repeat (6) @(posedge clock);
      chk(busy === 1'h1 && init_done === 1'h0, "in reset");
      sys_rst <= 1'h0;
      wait_init(t);
      chk(t >= 400 && busy === 1'h0, "init time");
      repeat (50) @(posedge clock);
      chk(init_done === 1'h1, "level retrigger");
      reinit_trigger <= 1'h0;
      avs(1'h0, dnup_pkg::REG_CTRL, '0, q);
      chk(q === dnup_pkg::CTRL_RST, "ctrl reset");
      avs(1'h0, dnup_pkg::REG_REFI, '0, q);
      chk(q[15:0] === dnup_pkg::TREFI_CYC, "refi reset");
      avs(1'h0, dnup_pkg::REG_ZQPER, '0, q);
      chk(q[15:0] === dnup_pkg::ZQ_PER_CYC, "zq period reset");
      avs(1'h0, 4'h6, '0, q);
      chk(q === '0, "unmapped");
      $display("test reset and registers done");
      req(1'h1, 4'h0, 16, 1'h0);
      mask_on <= 1'h1;
      req(1'h1, 4'hF, 16, 1'h1);
      req(1'h0, 4'hF, 16, 1'h0);
      req(1'h0, 4'h2, 1, 1'h1);
      repeat (40)
         req(1'($urandom), 4'($urandom), 1 + $urandom % 8, 1'($urandom));
      avs(1'h0, dnup_pkg::REG_STAT, '0, q);
      chk(q[31:16] === 16'(ap_cnt), "ap count");
      chk(q[0] === 1'h1, "stat ready");
      $display("test traffic done");
      avs(1'h1, dnup_pkg::REG_CTRL, 32'h0000_0001, q);
      repeat (4) @(posedge clock);
      z0 = n_ref;
      user_refresh_request <= 1'h1;
      @(posedge clock);
      user_refresh_request <= 1'h0;
      repeat (12) @(posedge clock);
      chk(n_ref - z0 == 1, "user refresh");
      avs(1'h1, dnup_pkg::REG_REFI, 32'h0000_0014, q);
      avs(1'h1, dnup_pkg::REG_CTRL, '0, q);
      repeat (80) @(posedge clock);
      chk(ref_gap == 21, "refresh spacing");
      avs(1'h1, dnup_pkg::REG_CTRL, 32'h0000_0001, q);
      $display("test refresh done");
      for (int r = 1; r < 4; r++)
      begin
         z0 = n_zq;
         zq_calib_request <= 2'(r);
         @(posedge clock);
         zq_calib_request <= '0;
         repeat (12) @(posedge clock);
         chk(n_zq - z0 == 1, "zq ack");
         avs(1'h0, dnup_pkg::REG_STAT, '0, q);
         chk(q[5:4] === 2'h0, "zq pending");
      end
      avs(1'h1, dnup_pkg::REG_ZQPER, 32'h0000_0010, q);
      avs(1'h1, dnup_pkg::REG_CTRL, 32'h0000_0003, q);
      z0 = n_zq;
      t = n_busy;
      repeat (60) @(posedge clock);
      chk(n_busy > t && n_zq == z0, "auto zq");
      avs(1'h1, dnup_pkg::REG_CTRL, 32'h0000_0001, q);
      $display("test zq done");
      reinit_trigger <= 1'h1;
      repeat (3) @(posedge clock);
      chk(init_done === 1'h0 && busy === 1'h1, "reinit");
      wait_init(t);
      chk(t >= 395, "reinit time");
      reinit_trigger <= 1'h0;
      req(1'h0, 4'h3, 2, 1'h0);
      $display("test reinit done");
      test_done();
   end
endmodule : tb
